// ===== logic/iodsl_pkg.sv
// Constants, register map and types for the I/O delay, SerDes and DDR block.
// Assumes a single 125 MHz APB clock that is also the delay reference clock.
// Operation
// - input delay line has 512 taps
// - fixed mode converts picoseconds to taps itself
// - variable-load mode takes a 9-bit tap value
// - output delay 512 taps, at most 1.25 ns
// - output delay line never cascades
// - input delay may cascade with output delay
// - DDR ratios 4/8, SDR ratios 2/4
// - optional bypassable 8-deep deserializer FIFO
// - capture register: async reset only, no enable
// - capture supports same, opposite, pipelined modes
// - output DDR has one async set/reset
// - output DDR works in same-edge mode only
// - output DDR idle three cycles after release
package iodsl_pkg;

  // Register byte offsets
  localparam logic [7:0] REG_CTRL       = 8'h00;
  localparam logic [7:0] REG_IN_DELAY   = 8'h04;
  localparam logic [7:0] REG_OUT_DELAY  = 8'h08;
  localparam logic [7:0] REG_REF_PERIOD = 8'h0C;
  localparam logic [7:0] REG_STATUS     = 8'h10;

  // Control register fields
  localparam int CTRL_IN_VAR_BIT   = 0;
  localparam int CTRL_CASCADE_BIT  = 1;
  localparam int CTRL_DDR_BIT      = 2;
  localparam int CTRL_RATIO_LSB    = 3;
  localparam int CTRL_FIFO_EN_BIT  = 5;
  localparam int CTRL_CAP_MODE_LSB = 6;
  localparam int CTRL_OUT_VAR_BIT  = 8;
  localparam int CTRL_W            = 9;
  localparam logic [CTRL_W-1:0] CTRL_RST = 9'h000;

  // Status register fields
  localparam int STAT_IN_TAPS_LSB  = 0;
  localparam int STAT_OUT_TAPS_LSB = 10;
  localparam int STAT_BUSY_BIT     = 19;
  localparam int STAT_OVF_BIT      = 20;
  localparam int STAT_ODDR_RDY_BIT = 21;

  // Delay line geometry and timing
  localparam int TAP_W                  = 9;
  localparam logic [TAP_W-1:0] TAP_MAX  = 9'h1FF;
  localparam int CLK_PERIOD_PS          = 8000;
  localparam logic [15:0] REF_PERIOD_RST = 16'(CLK_PERIOD_PS);
  localparam logic [15:0] OUT_MAX_PS    = 16'h04E2;
  localparam logic [1:0] ODDR_HOLD_CYC  = 2'h3;

  // Capture modes of the input DDR register
  typedef enum logic [1:0] {
    CAP_SAME   = 2'h0,
    CAP_MODE_A = 2'h1,
    CAP_MODE_B = 2'h2
  } iodsl_cap_mode_t;

  // Tap calculator states
  typedef enum logic [2:0] {
    ST_IDLE    = 3'h1,
    ST_DIV_IN  = 3'h2,
    ST_DIV_OUT = 3'h4
  } iodsl_cal_state_t;

endpackage : iodsl_pkg

// ===== logic/iodsl_word_fifo.sv
// Eight-entry word store for deserialized data with a registered output stage.
// Assumes writer and reader share one clock; a push while full is dropped.
module iodsl_word_fifo #(
  parameter int W     = 8,
  parameter int DEPTH = 8
) (
  input  wire logic         pclk,     // Clock
  input  wire logic         presetn,  // Async reset, active low
  input  wire logic         flush,    // Drop all words
  input  wire logic         wr_en,    // Push one word
  input  wire logic [W-1:0] wr_data,  // Word to push
  output logic              full,     // No room for a push
  output logic              rd_valid, // Output word present
  output logic [W-1:0]      rd_data,  // Output word, registered
  input  wire logic         rd_ready  // Reader takes the word
);
  localparam int PW = $clog2(DEPTH);

  logic [W-1:0] mem [DEPTH];
  logic [PW:0]  wptr_reg;
  logic [PW:0]  rptr_reg;
  logic         empty;
  logic         load;

  assign empty = (wptr_reg == rptr_reg);
  assign full  = ((wptr_reg - rptr_reg) == (PW+1)'(DEPTH));
  assign load  = !empty && (!rd_valid || rd_ready);

  // Storage has no reset; pointers and the output register need a defined value
  always_ff @(posedge pclk) begin
    if (wr_en && !full) begin
      mem[wptr_reg[PW-1:0]] <= wr_data;
    end
  end

  // Write pointer
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wptr_reg <= '0;
    end else if (flush) begin
      wptr_reg <= '0;
    end else if (wr_en && !full) begin
      wptr_reg <= wptr_reg + 1'b1;
    end
  end

  // Read pointer and output register
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rptr_reg <= '0;
      rd_valid <= 1'b0;
      rd_data  <= '0;
    end else if (flush) begin
      rptr_reg <= '0;
      rd_valid <= 1'b0;
    end else if (load) begin
      rd_data  <= mem[rptr_reg[PW-1:0]];
      rd_valid <= 1'b1;
      rptr_reg <= rptr_reg + 1'b1;
    end else if (rd_ready) begin
      rd_valid <= 1'b0;
    end
  end

endmodule : iodsl_word_fifo

// ===== logic/iodsl_top.sv
// I/O cell logic: delay tap control, DDR capture and drive, SerDes, word FIFO.
// Assumes pclk is also the delay reference and SerDes divided clock; pins are async.
module iodsl_top #(
  parameter logic [11:0] REF_TAPS_PER_PERIOD = 12'hC80, // Taps in one reference period
  parameter bit          SR_IS_SET           = 1'b0,    // Combined set/reset polarity
  parameter int          FIFO_DEPTH          = 8
) (
  input  wire logic        pclk,               // APB and reference clock
  input  wire logic        presetn,            // Async reset, active low
  input  wire logic [7:0]  paddr,              // APB address
  input  wire logic        psel,               // APB select
  input  wire logic        penable,            // APB enable
  input  wire logic        pwrite,             // APB direction
  input  wire logic [31:0] pwdata,             // APB write data
  output logic      [31:0] prdata,             // APB read data
  output logic             pready,             // APB ready
  output logic             pslverr,            // APB error, unmapped address
  input  wire logic        pin_in_rise,        // Pad sample, rising half
  input  wire logic        pin_in_fall,        // Pad sample, falling half
  output logic             pin_out_rise,       // Pad drive, rising half
  output logic             pin_out_fall,       // Pad drive, falling half
  output logic [8:0]       in_delay_taps,      // Input delay tap setting
  output logic [8:0]       out_delay_taps,     // Output delay tap setting
  output logic             delay_cascade,      // Input delay chains output delay
  output logic             cap_q1,             // Capture register, first bit
  output logic             cap_q2,             // Capture register, second bit
  input  wire logic [7:0]  tx_data,            // Parallel word to serialize
  input  wire logic        tx_valid,           // Word offered
  output logic             tx_ready,           // Serializer accepts a word
  output logic [7:0]       rx_data,            // Deserialized word
  output logic             rx_valid,           // Word present
  input  wire logic        rx_ready,           // Fabric takes the word
  input  wire logic        combined_set_reset  // Async set/reset of output DDR
);

  localparam logic [8:0] TAPS_MAX = iodsl_pkg::TAP_MAX;

  logic [iodsl_pkg::CTRL_W-1:0] ctrl_reg;
  logic [15:0] in_ps_reg;
  logic [15:0] out_ps_reg;
  logic [15:0] ref_ps_reg;
  logic        ovf_reg;
  logic        cal_pend_reg;
  logic        wr_acc;
  logic        rd_setup;
  logic        fifo_full;
  logic        fifo_vld;
  logic [7:0]  fifo_dat;
  logic        fifo_pop;
  logic        des_done;
  logic [1:0]  hold_reg;
  iodsl_pkg::iodsl_cal_state_t cal_st;

  // Control field views
  logic        in_var;
  logic        out_var;
  logic        ddr_mode;
  logic        fifo_en;
  logic [1:0]  ratio_sel;
  logic [3:0]  ratio;
  iodsl_pkg::iodsl_cap_mode_t cap_mode;

  assign in_var    = ctrl_reg[iodsl_pkg::CTRL_IN_VAR_BIT];
  assign out_var   = ctrl_reg[iodsl_pkg::CTRL_OUT_VAR_BIT];
  assign ddr_mode  = ctrl_reg[iodsl_pkg::CTRL_DDR_BIT];
  assign fifo_en   = ctrl_reg[iodsl_pkg::CTRL_FIFO_EN_BIT];
  assign ratio_sel = ctrl_reg[iodsl_pkg::CTRL_RATIO_LSB +: 2];
  assign cap_mode  = iodsl_pkg::iodsl_cap_mode_t'(ctrl_reg[iodsl_pkg::CTRL_CAP_MODE_LSB +: 2]);

  // Only native ratios exist; unsupported codes fall back to 4
  always_comb begin
    if (ddr_mode) begin
      ratio = (ratio_sel == 2'h2) ? 4'h8 : 4'h4;
    end else begin
      ratio = (ratio_sel == 2'h0) ? 4'h2 : 4'h4;
    end
  end

  // APB: answer one cycle after setup, write at the access edge
  assign rd_setup = psel && !penable;
  assign wr_acc   = psel && penable && pready && pwrite;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= 32'h0;
    end else begin
      pready  <= rd_setup;
      pslverr <= 1'b0;
      if (rd_setup) begin
        prdata <= 32'h0;
        case (paddr)
          iodsl_pkg::REG_CTRL:       prdata <= 32'(ctrl_reg);
          iodsl_pkg::REG_IN_DELAY:   prdata <= 32'(in_ps_reg);
          iodsl_pkg::REG_OUT_DELAY:  prdata <= 32'(out_ps_reg);
          iodsl_pkg::REG_REF_PERIOD: prdata <= 32'(ref_ps_reg);
          iodsl_pkg::REG_STATUS: begin
            prdata[iodsl_pkg::STAT_IN_TAPS_LSB +: 10] <=
              10'(in_delay_taps) + (delay_cascade ? 10'(out_delay_taps) : 10'h000);
            prdata[iodsl_pkg::STAT_OUT_TAPS_LSB +: 9] <= out_delay_taps;
            prdata[iodsl_pkg::STAT_BUSY_BIT]          <= cal_pend_reg || (cal_st != iodsl_pkg::ST_IDLE);
            prdata[iodsl_pkg::STAT_OVF_BIT]           <= ovf_reg;
            prdata[iodsl_pkg::STAT_ODDR_RDY_BIT]      <= (hold_reg == iodsl_pkg::ODDR_HOLD_CYC);
          end
          default: pslverr <= 1'b1;
        endcase
      end
    end
  end

  // Software-written configuration
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_reg   <= iodsl_pkg::CTRL_RST;
      in_ps_reg  <= 16'h0000;
      out_ps_reg <= 16'h0000;
      ref_ps_reg <= iodsl_pkg::REF_PERIOD_RST;
    end else if (wr_acc) begin
      case (paddr)
        iodsl_pkg::REG_CTRL:       ctrl_reg   <= pwdata[iodsl_pkg::CTRL_W-1:0];
        iodsl_pkg::REG_IN_DELAY:   in_ps_reg  <= pwdata[15:0];
        iodsl_pkg::REG_OUT_DELAY:  out_ps_reg <= (pwdata[15:0] > iodsl_pkg::OUT_MAX_PS) ?
                                                 iodsl_pkg::OUT_MAX_PS : pwdata[15:0];
        iodsl_pkg::REG_REF_PERIOD: ref_ps_reg <= pwdata[15:0];
        default: ;
      endcase
    end
  end

  // Cascade only extends the input path; output path is never chained
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      delay_cascade <= 1'b0;
    end else begin
      delay_cascade <= ctrl_reg[iodsl_pkg::CTRL_CASCADE_BIT];
    end
  end

  // Overflow flag: a new overflow beats a write-one clear
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ovf_reg <= 1'b0;
    end else if (des_done && fifo_en && fifo_full) begin
      ovf_reg <= 1'b1;
    end else if (wr_acc && paddr == iodsl_pkg::REG_STATUS && pwdata[iodsl_pkg::STAT_OVF_BIT]) begin
      ovf_reg <= 1'b0;
    end
  end

  // Tap recompute request; a new trigger beats the clear at the start
  logic cal_trig;
  assign cal_trig = wr_acc && (paddr == iodsl_pkg::REG_IN_DELAY ||
                               paddr == iodsl_pkg::REG_OUT_DELAY ||
                               paddr == iodsl_pkg::REG_REF_PERIOD);

  logic [27:0] div_rem_reg;
  logic [8:0]  div_q_reg;
  logic        div_step;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cal_pend_reg <= 1'b0;
    end else if (cal_trig) begin
      cal_pend_reg <= 1'b1;
    end else if (cal_st == iodsl_pkg::ST_IDLE) begin
      cal_pend_reg <= 1'b0;
    end
  end

  // Repeated subtraction: taps = ps * taps_per_period / period_ps, capped at 511
  assign div_step = (div_rem_reg >= 28'(ref_ps_reg)) && (div_q_reg != TAPS_MAX);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cal_st      <= iodsl_pkg::ST_IDLE;
      div_rem_reg <= 28'h0000000;
      div_q_reg   <= 9'h000;
    end else begin
      case (cal_st)
        iodsl_pkg::ST_IDLE: begin
          if (cal_pend_reg) begin
            div_rem_reg <= 28'(in_ps_reg) * 28'(REF_TAPS_PER_PERIOD);
            div_q_reg   <= 9'h000;
            cal_st      <= iodsl_pkg::ST_DIV_IN;
          end
        end
        iodsl_pkg::ST_DIV_IN: begin
          if (div_step) begin
            div_rem_reg <= div_rem_reg - 28'(ref_ps_reg);
            div_q_reg   <= div_q_reg + 9'h001;
          end else begin
            div_rem_reg <= 28'(out_ps_reg) * 28'(REF_TAPS_PER_PERIOD);
            div_q_reg   <= 9'h000;
            cal_st      <= iodsl_pkg::ST_DIV_OUT;
          end
        end
        iodsl_pkg::ST_DIV_OUT: begin
          if (div_step) begin
            div_rem_reg <= div_rem_reg - 28'(ref_ps_reg);
            div_q_reg   <= div_q_reg + 9'h001;
          end else begin
            cal_st <= iodsl_pkg::ST_IDLE;
          end
        end
        default: cal_st <= iodsl_pkg::ST_IDLE;
      endcase
    end
  end

  // Tap registers: direct 9-bit load in variable mode, calculator in fixed mode
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      in_delay_taps  <= 9'h000;
      out_delay_taps <= 9'h000;
    end else begin
      if (in_var && wr_acc && paddr == iodsl_pkg::REG_IN_DELAY) begin
        in_delay_taps <= pwdata[8:0];
      end else if (!in_var && cal_st == iodsl_pkg::ST_DIV_IN && !div_step) begin
        in_delay_taps <= div_q_reg;
      end
      if (out_var && wr_acc && paddr == iodsl_pkg::REG_OUT_DELAY) begin
        out_delay_taps <= pwdata[8:0];
      end else if (!out_var && cal_st == iodsl_pkg::ST_DIV_OUT && !div_step) begin
        out_delay_taps <= div_q_reg;
      end
    end
  end

  // Pad samples cross into pclk through two flops each
  logic [1:0] pin_meta_reg;
  logic [1:0] pin_sync_reg;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pin_meta_reg <= 2'h0;
      pin_sync_reg <= 2'h0;
    end else begin
      pin_meta_reg <= {pin_in_fall, pin_in_rise};
      pin_sync_reg <= pin_meta_reg;
    end
  end

  // Capture register: async reset only, no enable, no set
  logic [1:0] cap_prev_reg;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cap_prev_reg <= 2'h0;
      cap_q1       <= 1'b0;
      cap_q2       <= 1'b0;
    end else begin
      cap_prev_reg <= pin_sync_reg;
      case (cap_mode)
        iodsl_pkg::CAP_SAME: begin
          cap_q1 <= pin_sync_reg[0];
          cap_q2 <= cap_prev_reg[1];
        end
        iodsl_pkg::CAP_MODE_A: begin
          cap_q1 <= pin_sync_reg[0];
          cap_q2 <= pin_sync_reg[1];
        end
        iodsl_pkg::CAP_MODE_B: begin
          cap_q1 <= cap_prev_reg[0];
          cap_q2 <= cap_prev_reg[1];
        end
        default: begin
          cap_q1 <= pin_sync_reg[0];
          cap_q2 <= cap_prev_reg[1];
        end
      endcase
    end
  end

  // Deserializer: fills LSB first, two bits per cycle in DDR; no bit slip
  logic [7:0] des_sh_reg;
  logic [3:0] des_cnt_reg;
  logic [7:0] des_word;
  logic [3:0] des_cnt_nxt;

  always_comb begin
    des_word = des_sh_reg;
    des_word[des_cnt_reg[2:0]] = cap_q1;
    if (ddr_mode) begin
      des_word[3'(des_cnt_reg[2:0] + 3'h1)] = cap_q2;
    end
    des_cnt_nxt = des_cnt_reg + (ddr_mode ? 4'h2 : 4'h1);
  end
  assign des_done = (des_cnt_nxt >= ratio);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      des_sh_reg  <= 8'h00;
      des_cnt_reg <= 4'h0;
    end else if (des_done) begin
      des_sh_reg  <= 8'h00;
      des_cnt_reg <= 4'h0;
    end else begin
      des_sh_reg  <= des_word;
      des_cnt_reg <= des_cnt_nxt;
    end
  end

  // Word FIFO lets fabric drain at its own pace; bypass overwrites instead
  iodsl_word_fifo #(
    .W     (8),
    .DEPTH (FIFO_DEPTH)
  ) u_fifo (
    .pclk     (pclk),
    .presetn  (presetn),
    .flush    (!fifo_en),
    .wr_en    (des_done && fifo_en),
    .wr_data  (des_word),
    .full     (fifo_full),
    .rd_valid (fifo_vld),
    .rd_data  (fifo_dat),
    .rd_ready (fifo_pop)
  );
  assign fifo_pop = fifo_en && (!rx_valid || rx_ready);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rx_valid <= 1'b0;
      rx_data  <= 8'h00;
    end else if (!fifo_en) begin
      if (des_done) begin
        rx_valid <= 1'b1;
        rx_data  <= des_word;
      end else if (rx_ready) begin
        rx_valid <= 1'b0;
      end
    end else if (fifo_pop) begin
      rx_valid <= fifo_vld;
      rx_data  <= fifo_dat;
    end
  end

  // Output DDR hold-off counter: three cycles after set/reset release
  logic       oddr_rdy;
  assign oddr_rdy = (hold_reg == iodsl_pkg::ODDR_HOLD_CYC);

  always_ff @(posedge pclk or negedge presetn or posedge combined_set_reset) begin
    if (!presetn || combined_set_reset) begin
      hold_reg <= 2'h0;
    end else if (!oddr_rdy) begin
      hold_reg <= hold_reg + 2'h1;
    end
  end

  // Serializer: LSB first, stalls while the output register is held off
  logic [7:0] ser_sh_reg;
  logic [3:0] ser_cnt_reg;
  logic [3:0] ser_cnt_nxt;
  logic       ser_take;
  logic       ser_shift;

  assign ser_take  = tx_valid && tx_ready;
  assign ser_shift = oddr_rdy && (ser_cnt_reg != 4'h0);

  always_comb begin
    ser_cnt_nxt = ser_cnt_reg;
    if (ser_take) begin
      ser_cnt_nxt = ratio;
    end else if (ser_shift) begin
      ser_cnt_nxt = ser_cnt_reg - (ddr_mode ? 4'h2 : 4'h1);
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ser_sh_reg  <= 8'h00;
      ser_cnt_reg <= 4'h0;
      tx_ready    <= 1'b0;
    end else begin
      ser_cnt_reg <= ser_cnt_nxt;
      tx_ready    <= (ser_cnt_nxt == 4'h0) && !ser_take;
      if (ser_take) begin
        ser_sh_reg <= tx_data;
      end else if (ser_shift) begin
        ser_sh_reg <= ddr_mode ? {2'h0, ser_sh_reg[7:2]} : {1'h0, ser_sh_reg[7:1]};
      end
    end
  end

  // Output DDR register: same-edge only, one async set/reset, loads only when ser_shift
  always_ff @(posedge pclk or negedge presetn or posedge combined_set_reset) begin
    if (!presetn || combined_set_reset) begin
      pin_out_rise <= SR_IS_SET;
      pin_out_fall <= SR_IS_SET;
    end else if (ser_shift) begin
      pin_out_rise <= ser_sh_reg[0];
      pin_out_fall <= ddr_mode ? ser_sh_reg[1] : ser_sh_reg[0];
    end
  end

endmodule : iodsl_top

// ===== test/iodsl_top_sva.sv
// Port checker for iodsl_top: APB timing, output DDR set/reset, serializer pacing.
// Assumes one clock pclk and async active-low presetn.
module iodsl_top_chk #(
  parameter bit SR_IS_SET = 1'b0
) (
  input wire logic        pclk,               // Clock
  input wire logic        presetn,            // Reset, active low
  input wire logic [7:0]  paddr,              // Address
  input wire logic        psel,               // Select
  input wire logic        penable,            // Enable
  input wire logic        pwrite,             // Direction
  input wire logic [31:0] pwdata,             // Write data
  input wire logic [31:0] prdata,             // Read data
  input wire logic        pready,             // Ready
  input wire logic        pslverr,            // Error
  input wire logic        pin_out_rise,       // Pad drive
  input wire logic        pin_out_fall,       // Pad drive
  input wire logic        delay_cascade,      // Cascade flag
  input wire logic        tx_valid,           // Word offered
  input wire logic        tx_ready,           // Serializer ready
  input wire logic        rx_valid,           // Word present
  input wire logic        rx_ready,           // Word taken
  input wire logic        combined_set_reset  // Output DDR set/reset
);
  timeunit 1ns;
  timeprecision 100ps;
  // Decoded bus phases and address map
  wire logic setup_c = psel && !penable;
  wire logic map_c   = paddr inside {8'h00, 8'h04, 8'h08, 8'h0C, 8'h10};
  wire logic wr_c    = psel && penable && pready && pwrite;
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  property p_rdy_setup; setup_c |=> pready; endproperty
  a_rdy_setup: assert property (p_rdy_setup) else $error("pready late");
  property p_rdy_cause; pready |-> $past(setup_c); endproperty
  a_rdy_cause: assert property (p_rdy_cause) else $error("pready without setup");
  property p_unmapped; setup_c && !map_c |=> pslverr && prdata == 32'h0; endproperty
  a_unmapped: assert property (p_unmapped) else $error("unmapped not refused");
  property p_cascade;
    logic v;
    (wr_c && paddr == 8'h00, v = pwdata[1]) |-> ##2 delay_cascade == v;
  endproperty
  a_cascade: assert property (p_cascade) else $error("cascade flag wrong");
  // Async force shows at every sampled edge while held
  property p_sr_force;
    combined_set_reset |-> pin_out_rise == SR_IS_SET && pin_out_fall == SR_IS_SET;
  endproperty
  a_sr_force: assert property (p_sr_force) else $error("set/reset not forced");
  property p_sr_hold;
    $fell(combined_set_reset) |-> (pin_out_rise == SR_IS_SET && pin_out_fall == SR_IS_SET)[*3];
  endproperty
  a_sr_hold: assert property (p_sr_hold) else $error("drive before hold end");
  property p_tx_busy; tx_valid && tx_ready |=> !tx_ready [*2] ##[1:4] tx_ready; endproperty
  a_tx_busy: assert property (p_tx_busy) else $error("serializer pacing wrong");
  property p_rx_hold; rx_valid && !rx_ready |=> rx_valid; endproperty
  a_rx_hold: assert property (p_rx_hold) else $error("word lost before take");
  c_unmapped: cover property (setup_c && !map_c);
  c_tx_take: cover property (tx_valid && tx_ready);
  c_sr_release: cover property ($fell(combined_set_reset));
endmodule : iodsl_top_chk

bind iodsl_top iodsl_top_chk #(.SR_IS_SET(SR_IS_SET)) chk_u (
  .pclk, .presetn, .paddr, .psel, .penable, .pwrite, .pwdata, .prdata, .pready, .pslverr,
  .pin_out_rise, .pin_out_fall, .delay_cascade, .tx_valid, .tx_ready, .rx_valid, .rx_ready,
  .combined_set_reset
);

// ===== test/iodsl_fabric_model.sv
// Fabric-side model: offers words to the serializer, takes deserialized words.
// Assumes it shares pclk with the block, so no crossing is needed.
module iodsl_fabric_model (
  input  wire logic       pclk,     // Clock
  input  wire logic       presetn,  // Reset, active low
  output logic      [7:0] tx_data,  // Word offered
  output logic            tx_valid, // Offer strobe
  input  wire logic       tx_ready, // Serializer ready
  input  wire logic       rx_valid, // Word present
  output logic            rx_ready  // Take strobe
);
  timeunit 1ns;
  timeprecision 100ps;
  // No tri-states, no RAM
  // Idle offer; words are taken unless the bench stalls
  initial begin
    tx_data  = 8'h00;
    tx_valid = 1'b0;
  end
  // One word held until taken; only native ratios asked, no slip
  task automatic send(input logic [7:0] w);
    logic rdy;
    @(posedge pclk);
    tx_data  <= w;
    tx_valid <= 1'b1;
    do begin
      @(negedge pclk);
      rdy = tx_ready;
      @(posedge pclk);
    end while (rdy !== 1'b1);
    tx_valid <= 1'b0;
    tx_data  <= ~w;  // Released data never repeats the word
  endtask : send
endmodule : iodsl_fabric_model

// ===== test/iodsl_top_tb.sv
// Self-checking bench for iodsl_top over APB, with a fabric model.
// Assumes pads loop back, so capture sees the serializer drive.
module iodsl_top_tb;
  timeunit 1ns;
  timeprecision 100ps;
  logic        pclk, presetn, psel, penable, pwrite, e;
  logic [7:0]  paddr, tx_data;
  logic [31:0] pwdata, prdata, q;
  logic        pready, pslverr, pin_out_rise, pin_out_fall, delay_cascade, cap_q1, cap_q2;
  logic [8:0]  in_delay_taps, out_delay_taps;
  logic        tx_valid, tx_ready, rx_valid, rx_ready, combined_set_reset;
  int          fails, n_compared;
  logic [7:0]  mode_tab [4] = '{8'h00, 8'h08, 8'h04, 8'h14};
  logic [7:0]  word_tab [4] = '{8'hC6, 8'h09, 8'hB3, 8'h5A};
  int          len_tab [4]  = '{2, 4, 4, 8};

  iodsl_top dut_u (
    .pclk, .presetn, .paddr, .psel, .penable, .pwrite, .pwdata, .prdata, .pready, .pslverr,
    .pin_in_rise(pin_out_rise), .pin_in_fall(pin_out_fall), .pin_out_rise, .pin_out_fall,
    .in_delay_taps, .out_delay_taps, .delay_cascade, .cap_q1, .cap_q2, .tx_data, .tx_valid,
    .tx_ready, .rx_data(), .rx_valid, .rx_ready, .combined_set_reset
  );
  iodsl_fabric_model fab_u (.pclk, .presetn, .tx_data, .tx_valid, .tx_ready, .rx_valid,
                            .rx_ready);

  initial begin
    pclk = 1'b0;
    forever #4 pclk = ~pclk;
  end

  task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] x);
    n_compared++;
    if (got !== x) begin
      fails++;
      $display("[ERR] %s expected %h seen %h", nm, x, got);
    end
  endtask : chk

  // One transfer; data taken at the edge that sees pready
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
                     output logic [31:0] r, output logic er);
    logic rdy;
    int   n;
    n = 0;
    @(posedge pclk);
    psel   <= 1'b1;
    pwrite <= w;
    paddr  <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      rdy = pready;
      r   = prdata;
      er  = pslverr;
      n++;
    end while (rdy !== 1'b1 && n < 16);
    psel    <= 1'b0;
    penable <= 1'b0;
    if (rdy !== 1'b1) fails++;
  endtask : apb

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d, q, e);
  endtask : wr

  task automatic rd(input logic [7:0] a, input logic [31:0] x, input string nm);
    apb(1'b0, a, 32'h0, q, e);
    chk(nm, q, x);
  endtask : rd

  // Poll busy; the divider takes one cycle per subtraction
  task automatic wait_calc;
    int n;
    n = 0;
    do begin
      apb(1'b0, 8'h10, 32'h0, q, e);
      n++;
    end while (q[19] !== 1'b0 && n < 1500);
    if (q[19] !== 1'b0) fails++;
  endtask : wait_calc

  task automatic results;
    $display("Compared %0d, mismatches %0d", n_compared, fails);
    if (fails == 0 && n_compared > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask : results

  // Hang guard
  initial begin
    repeat (40000) @(posedge pclk);
    fails++;
    results();
  end

  initial begin
    int b;
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    combined_set_reset = 1'b0;
    fab_u.rx_ready = 1'b1;
    fails = 0;
    n_compared = 0;
    repeat (16) @(posedge pclk);
    presetn <= 1'b1;
    // Reset values, then a refused access
    rd(8'h0C, 32'h1F40, "ref_period");
    rd(8'h10, 32'h0020_0000, "status");
    rd(8'h14, 32'h0, "unmapped");
    chk("slverr", e, 32'h1);
    // Variable load acts at the write edge
    wr(8'h00, 32'h101);
    wr(8'h04, 32'h2A5);
    @(negedge pclk);
    chk("in_taps", in_delay_taps, 32'h0A5);
    wr(8'h08, 32'h155);
    @(negedge pclk);
    chk("out_taps", out_delay_taps, 32'h155);
    wr(8'h00, 32'h103);
    wait_calc();
    chk("cascade", delay_cascade, 32'h1);
    rd(8'h10, 32'h0020_0000 | (32'h155 << 10) | 32'h1FA, "status_casc");
    // Fixed mode: cap at 511, clamp at 1250 ps, reference rescale
    wr(8'h00, 32'h0);
    wr(8'h04, 32'd2000);
    wait_calc();
    wr(8'h08, 32'd2000);
    wait_calc();
    chk("in_cap", in_delay_taps, 32'h1FF);
    chk("out_clamp", out_delay_taps, 32'h1F4);
    rd(8'h08, 32'h4E2, "out_ps");
    wr(8'h0C, 32'd16000);
    wait_calc();
    rd(8'h10, 32'h0020_0000 | (32'hFA << 10) | 32'h190, "status_fix");
    // Every native ratio, LSB first on the pads
    for (int i = 0; i < 4; i++) begin
      wr(8'h00, {24'h0, mode_tab[i]});
      fab_u.send(word_tab[i]);
      @(posedge pclk);
      for (int k = 0; k < len_tab[i] / (mode_tab[i][2] ? 2 : 1); k++) begin
        @(negedge pclk);
        b = mode_tab[i][2] ? 2 * k : k;
        chk("ser_rise", pin_out_rise, word_tab[i][b]);
        chk("ser_fall", pin_out_fall, word_tab[i][mode_tab[i][2] ? b + 1 : b]);
      end
    end
    // Each capture mode settles on the idle pad levels
    for (int m = 0; m < 3; m++) begin
      wr(8'h00, 32'(m) << 6);
      repeat (6) @(negedge pclk);
      chk("cap_q1", cap_q1, pin_out_rise);
      chk("cap_q2", cap_q2, pin_out_fall);
    end
    // FIFO overflow while stalled, then sticky clear
    wr(8'h00, 32'h20);
    fab_u.rx_ready <= 1'b0;
    repeat (40) @(posedge pclk);
    apb(1'b0, 8'h10, 32'h0, q, e);
    chk("ovf_set", q[20], 32'h1);
    fab_u.rx_ready <= 1'b1;
    repeat (30) @(posedge pclk);
    wr(8'h10, 32'h0010_0000);
    apb(1'b0, 8'h10, 32'h0, q, e);
    chk("ovf_clr", q[20], 32'h0);
    wr(8'h00, 32'h04);
    // Set/reset forces pads, then a send right after release
    combined_set_reset <= 1'b1;
    @(negedge pclk);
    chk("sr_pin", pin_out_rise, 32'h0);
    apb(1'b0, 8'h10, 32'h0, q, e);
    chk("sr_ready", q[21], 32'h0);
    combined_set_reset <= 1'b0;
    fab_u.send(8'h0F);
    rd(8'h0C, 32'd16000, "ref_keep");
    results();
  end
endmodule : iodsl_top_tb
